// *** verif/fcs_cpu_model.sv ***
// cpu side bus master issuing single command cycles
`timescale 1ns/1ps
module fcs_cpu_model (
  input  wire        ref_clk,
  output reg         wr_stb,
  output reg         rd_stb,
  output reg  [23:0] bus_addr,
  output reg  [31:0] bus_wdata,
  output reg  [3:0]  bus_be
);
  initial begin
    {wr_stb, rd_stb, bus_addr, bus_wdata, bus_be} = 62'h0;
  end
  // released address and data lines show the inverse, strobes and byte enables go low, so stale values never look valid
  task cyc(input rd, input [23:0] a, input [31:0] d, input [3:0] be);
    begin
      @(posedge ref_clk) #1;
      {wr_stb, rd_stb, bus_addr, bus_wdata, bus_be} = {!rd, rd, a, d, be};
      @(posedge ref_clk) #1;
      {wr_stb, rd_stb, bus_addr, bus_wdata, bus_be} = {2'b00, ~a, ~d, 4'h0};
      repeat (2) @(posedge ref_clk);
    end
  endtask
endmodule

// *** verif/fcs_seq_props.sv ***
// port assertions for the flash command sequencer
`timescale 1ns/1ps
module fcs_seq_props (
  input wire        ref_clk,
  input wire        rst_n,
  input wire        wr_stb,
  input wire        rd_stb,
  input wire [23:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire        ready_busy_flag,
  input wire        read_mode,
  input wire [7:0]  status_byte,
  input wire        query_valid,
  input wire        op_start,
  input wire [2:0]  op_kind
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // busy and status follow a started operation
  AST_START_BUSY: assert property (op_start |-> !ready_busy_flag)
    else $error("op started while ready");
  AST_BUSY_IGNORE: assert property (!ready_busy_flag && wr_stb |=> !op_start)
    else $error("write during busy started an op");
  AST_QUERY_CAUSE: assert property (query_valid |-> $past(rd_stb))
    else $error("query result without a read");
  AST_TMO_BITS: assert property (status_byte[5] |-> status_byte[3])
    else $error("timeout without bit 3");
  AST_PROG_STAT: assert property (op_start && op_kind == 3'h0 ##1 !ready_busy_flag
    |-> !status_byte[5] && !status_byte[3]) else $error("program status wrong");
  AST_ERASE_STAT: assert property (op_start && op_kind == 3'h1 ##1 !ready_busy_flag
    |-> status_byte[3] && !status_byte[7]) else $error("erase status wrong");
  // limited by the shortened op length and timeout
  AST_DONE_BOUND: assert property (op_start
    |-> ##[1:40] (ready_busy_flag || status_byte[5]))
    else $error("op neither finished nor timed out");
  AST_F0_READ: assert property (wr_stb && bus_wdata[7:0] == 8'hF0 && bus_addr[3:0] == 4'h0
    && (ready_busy_flag || status_byte[5]) |-> ##[1:2] read_mode) else $error("reset no read");
endmodule
bind fcs_sequencer fcs_seq_props i_props (.ref_clk, .rst_n, .wr_stb, .rd_stb, .bus_addr,
  .bus_wdata, .ready_busy_flag, .read_mode, .status_byte, .query_valid, .op_start, .op_kind);

// *** verif/testbench.sv ***
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`include "fcs_map.vh"
module testbench;
  reg         ref_clk = 1'b0, rst_n = 1'b0, sel = 1'b0, op_fail = 1'b0;
  reg  [18:0] pmap = 19'h00000, off;
  reg  [5:0]  strap = 6'h20;
  reg  [31:0] exp_pv;
  reg  [23:0] exp_pa;
  wire        wr_stb, rd_stb, rdy, rmode, qv, pmode, aerr, ostart, secb;
  wire [23:0] addr, pta;
  wire [31:0] wdata, pqr, pval;
  wire [3:0]  be;
  wire [7:0]  stat;
  wire [2:0]  kind;
  wire [4:0]  oblk;
  integer     n_mismatch = 0, n_compared = 0, n_qv = 0, n_ae = 0, exp_bd, e, i, w;
  integer     exp_q[$];
  always #10 ref_clk = ~ref_clk;
  fcs_sequencer #(.ERASE_WIN_CYC(5), .OP_CYC(4), .TIMEOUT_CYC(20)) i_dut (.ref_clk(ref_clk),
    .rst_n(rst_n), .wr_stb(wr_stb), .rd_stb(rd_stb), .bus_addr(addr), .bus_wdata(wdata),
    .bus_be(be), .security_access_select(sel), .block_protect_map(pmap), .op_fail(op_fail),
    .rst_pin_n(strap[5]), .bus_width_strap_lo(strap[4]), .bus_width_strap_hi(strap[3]),
    .mode_strap_a(strap[2]), .mode_strap_b(strap[1]), .mode_strap_c(strap[0]),
    .ready_busy_flag(rdy), .read_mode(rmode), .status_byte(stat), .protect_query_result(pqr),
    .query_valid(qv), .programmer_mode(pmode), .access_error(aerr), .op_start(ostart),
    .op_kind(kind), .program_target_addr(pta), .program_value(pval), .op_block(oblk),
    .security_bit(secb));
  fcs_cpu_model i_cpu (.ref_clk(ref_clk), .wr_stb(wr_stb), .rd_stb(rd_stb), .bus_addr(addr),
    .bus_wdata(wdata), .bus_be(be));
  task chk(input [8*20-1:0] n, input [31:0] x, input [31:0] s);
    begin
      n_compared = n_compared + 1;
      if (s !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0s expected %h seen %h", n, x, s);
      end
    end
  endtask
  // block index from array offset, small blocks at the top
  function integer blk(input [18:0] o);
    blk = o < 19'h78000 ? o[18:15] : o < 19'h7C000 ? 15 : o < 19'h7E000 ? 16 :
          o < 19'h7F000 ? 17 : 18;
  endfunction
  task wb(input [23:0] a, input [7:0] d);
    i_cpu.cyc(1'b0, a, {24'h000000, d}, 4'h1);
  endtask
  task unl(input [23:0] a, input [7:0] c);
    begin
      wb(`FCS_ADDR_UNLOCK1, 8'hAA);
      wb(`FCS_ADDR_UNLOCK2, 8'h55);
      wb(a, c);
    end
  endtask
  task prog;
    begin
      w = $urandom;
      exp_pa = {5'h00, w[18:2], 2'b00};
      exp_pv = $urandom;
      // an F0 byte at an xxx0 address would read as a reset, not data
      if (exp_pv[7:0] == `FCS_CMD_RESET && exp_pa[3:0] == 4'h0) exp_pv[7:0] = 8'h0F;
      unl(`FCS_ADDR_UNLOCK1, 8'hA0);
      i_cpu.cyc(1'b0, exp_pa, exp_pv, 4'hF);
    end
  endtask
  // bounded wait for the ready flag
  task done;
    begin
      repeat (10) @(posedge ref_clk);
      for (w = 0; w < 80 && rdy !== 1'b1; w = w + 1) @(posedge ref_clk);
      chk("ready_busy_flag", 1, rdy);
    end
  endtask
  task final_report;
    begin
      if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // model of expected results, checked at every design result
  always @(posedge ref_clk) begin
    if (qv === 1'b1) begin
      n_qv = n_qv + 1;
      chk("protect_query_result", exp_bd, pqr);
    end
    if (aerr === 1'b1) n_ae = n_ae + 1;
    if (ostart === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 7;
      chk("op_kind", e % 8, kind);
      if (e % 8 == 2) chk("op_block", e / 8, oblk);
      if (e % 8 == 0) chk("program_value", exp_pv, pval);
      if (e % 8 == 0) chk("program_target_addr", exp_pa, pta);
    end
  end
  initial begin
    #(20 * 4000);
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  initial begin
    e = $urandom(82);
    // random low straps; the reset pin held high keeps normal mode
    w = $urandom;
    strap[4:0] = w[4:0];
    repeat (4) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    exp_q.push_back(0);
    prog;
    done;
    exp_q.push_back(1);
    unl(`FCS_ADDR_UNLOCK1, 8'h80);
    unl(`FCS_ADDR_UNLOCK1, 8'h10);
    done;
    // block erase at boundaries of the small blocks and at random
    for (i = 0; i < 5; i = i + 1) begin
      w = $urandom;
      off = i == 0 ? 19'h77FFC : i == 1 ? 19'h7C000 : i == 2 ? 19'h7EFFC : i == 3 ? 19'h7FFFC
            : w[18:0];
      off[1:0] = 2'b00;
      exp_q.push_back(2 + 8 * blk(off));
      unl(`FCS_ADDR_UNLOCK1, 8'h80);
      unl({5'h00, off}, 8'h30);
      done;
    end
    #1 w = $urandom;
    pmap = w[18:0];
    for (i = 0; i < 3; i = i + 1) begin
      w = $urandom;
      off = (w[18:0] & 19'h7FFB4) | 19'h00010;
      exp_bd = pmap[blk(off)];
      unl(`FCS_ADDR_UNLOCK1, 8'h90);
      i_cpu.cyc(1'b1, {5'h00, off}, 32'h00000000, 4'hF);
      wb(24'h000000, 8'hF0);
    end
    chk("query count", 3, n_qv);
    #1 sel = 1'b1;
    exp_q.push_back(3);
    unl(`FCS_ADDR_UNLOCK1, 8'hA0);
    wb(`FCS_ADDR_ZERO, 8'h98);
    done;
    chk("security_bit on", 1, secb);
    // block erase is refused while secured: no window, no op
    #1 sel = 1'b0;
    unl(`FCS_ADDR_UNLOCK1, 8'h80);
    unl({5'h00, off}, 8'h30);
    chk("read_mode secured", 1, rmode);
    #1 sel = 1'b1;
    exp_q.push_back(4);
    unl(`FCS_ADDR_UNLOCK1, 8'h80);
    unl(`FCS_ADDR_UNLOCK1, 8'h10);
    done;
    chk("security_bit off", 0, secb);
    #1 sel = 1'b0;
    // broken second unlock byte must start nothing
    wb(`FCS_ADDR_UNLOCK1, 8'hAA);
    wb(`FCS_ADDR_UNLOCK2, 8'h5A);
    wb(`FCS_ADDR_UNLOCK1, 8'hA0);
    i_cpu.cyc(1'b0, 24'h000100, $urandom, 4'hF);
    chk("read_mode abort", 1, rmode);
    #1 op_fail = 1'b1;
    exp_q.push_back(0);
    prog;
    repeat (40) @(posedge ref_clk);
    chk("timeout bits", {~exp_pv[7], 2'b11}, {stat[7], stat[5], stat[3]});
    prog;
    chk("busy held", 0, rdy);
    #1 op_fail = 1'b0;
    wb(24'h012340, 8'hF0);
    chk("ready after reset cmd", 2'b11, {rdy, rmode});
    chk("queue empty", 0, exp_q.size());
    chk("normal mode", 0, pmode);
    // one strap off first, then the exact programmer strap set
    for (i = 0; i < 2; i = i + 1) begin
      #1 rst_n = 1'b0;
      strap = i ? 6'h0C : 6'h0C ^ (6'h01 << ($urandom % 6));
      repeat (4) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge ref_clk);
      chk("programmer_mode", i, pmode);
    end
    wb(24'h000011, 8'hF0);
    wb(24'h080000, 8'hF0);
    chk("access errors", 2, n_ae);
    final_report;
  end
endmodule

// *** verilog/fcs_block_decode.v ***
// maps an array byte offset to one of the erase blocks
`timescale 1ns/1ps
module fcs_block_decode (
  input  wire [18:0] offset,
  output reg  [4:0]  block
);
  // 15 big blocks of 32K, then 16K, 8K, 4K, 4K at the top
  always @* begin
    if (offset[18:15] != 4'hF)
      block = {1'b0, offset[18:15]};
    else if (offset[14] == 1'b0)
      block = 5'h0F;
    else if (offset[13] == 1'b0)
      block = 5'h10;
    else if (offset[12] == 1'b0)
      block = 5'h11;
    else
      block = 5'h12;
  end
endmodule

// *** verilog/fcs_map.vh ***
// constants for the flash command sequencer
`ifndef FCS_MAP_VH
`define FCS_MAP_VH
`define FCS_ADDR_UNLOCK1   16'hAAA8
`define FCS_ADDR_UNLOCK2   16'h5554
`define FCS_ADDR_ZERO      16'h0000
`define FCS_DAT_UNLOCK1    8'hAA
`define FCS_DAT_UNLOCK2    8'h55
`define FCS_CMD_RESET      8'hF0
`define FCS_CMD_PROGRAM    8'hA0
`define FCS_CMD_ERASE      8'h80
`define FCS_CMD_CHIP       8'h10
`define FCS_CMD_BLOCK      8'h30
`define FCS_CMD_VERIFY     8'h90
`define FCS_CMD_PROTECT    8'h9A
`define FCS_DAT_SECURE     8'h98
`define FCS_PROG_TOP       24'h07FFFF
`define FCS_NUM_BLOCKS     19
`define FCS_CLK_MHZ        50
`define FCS_ERASE_WIN_US   50
`define FCS_ERASE_WIN_CYC  (`FCS_ERASE_WIN_US * `FCS_CLK_MHZ)
`endif

// *** verilog/fcs_sequencer.v ***
// command decoder and write status reporter for the on-chip flash array
`timescale 1ns/1ps
`include "fcs_map.vh"
// Behaviour
// - unlock AA@AAA8, 55@5554, then command@AAA8
// - decode F0 A0 80 10 30 90; 9A falls back to read
// - compare low 16 bits; F0@xxx0 resets (ignored in the block erase window, where the erase still starts)
// - chip erase/security off six cycles
// - block erase 30 at block address
// - nineteen blocks of mixed sizes
// - verify protect: 90 then tagged read
// - verify read returns one when protected
// - security on: A0 then 98@0000
// - status bits 7,5,3 during operations
// - timeout drives bits 5,3 high
// - programmer mode from reset straps
// - programmer map 0 to 7FFFF
// - programmer accesses are halfword aligned
// - ignore commands while busy
// - invalid sequence returns to read (writes other than an aligned 30 in the erase window are ignored)
module fcs_sequencer #(
  parameter ERASE_WIN_CYC = `FCS_ERASE_WIN_CYC,
  parameter OP_CYC        = 64,
  parameter TIMEOUT_CYC   = 100000
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        wr_stb,
  input  wire        rd_stb,
  input  wire [23:0] bus_addr,
  input  wire [31:0] bus_wdata,
  input  wire [3:0]  bus_be,
  input  wire        security_access_select,
  input  wire [18:0] block_protect_map,
  input  wire        op_fail,
  input  wire        rst_pin_n,
  input  wire        bus_width_strap_lo,
  input  wire        bus_width_strap_hi,
  input  wire        mode_strap_a,
  input  wire        mode_strap_b,
  input  wire        mode_strap_c,
  output reg         ready_busy_flag,
  output reg         read_mode,
  output reg  [7:0]  status_byte,
  output reg  [31:0] protect_query_result,
  output reg         query_valid,
  output reg         programmer_mode,
  output reg         access_error,
  output reg         op_start,
  output reg  [2:0]  op_kind,
  output reg  [23:0] program_target_addr,
  output reg  [31:0] program_value,
  output reg  [4:0]  op_block,
  output reg         security_bit
);
  // sequence states
  localparam S_IDLE = 4'd0, S_U1 = 4'd1, S_U2 = 4'd2, S_PGM = 4'd3, S_ERS = 4'd4;
  localparam S_EU1 = 4'd5, S_EU2 = 4'd6, S_VFY = 4'd7, S_RUN = 4'd8, S_WIN = 4'd9;
  localparam S_FAIL = 4'd10, S_SEC = 4'd11;
  // operation kinds
  localparam K_PROG = 3'd0, K_CHIP = 3'd1, K_BLOCK = 3'd2, K_SON = 3'd3, K_SOFF = 3'd4;

  // state and timers
  reg  [3:0]  st_q;
  reg  [31:0] cnt_q;
  reg  [31:0] tmo_q;
  reg         poll_q;
  // two-flop synchronisers for the strap pins
  reg  [1:0]  sy_rst, sy_bw0, sy_bw1, sy_pa, sy_pb, sy_pc;
  // strap capture happens once per reset
  reg         strap_done_q;
  // command decode helpers; the region bits above 15 never take part
  wire [15:0] a16 = bus_addr[15:0];
  wire [7:0]  d8  = bus_wdata[7:0];
  wire        at_u1 = (a16 == `FCS_ADDR_UNLOCK1);
  wire        at_u2 = (a16 == `FCS_ADDR_UNLOCK2);
  // block decode output
  wire [4:0]  blk;
  wire        is_reset1 = wr_stb && (a16[3:0] == 4'h0) && (d8 == `FCS_CMD_RESET);
  wire        misalign;

  // erase block index of the current address
  fcs_block_decode u_dec (
    .offset (bus_addr[18:0]),
    .block  (blk)
  );

  // straps pass two flops; sampled once on the first cycle after reset
  always @(posedge ref_clk) begin
    sy_rst <= {sy_rst[0], rst_pin_n};
    sy_bw0 <= {sy_bw0[0], bus_width_strap_lo};
    sy_bw1 <= {sy_bw1[0], bus_width_strap_hi};
    sy_pa  <= {sy_pa[0], mode_strap_a};
    sy_pb  <= {sy_pb[0], mode_strap_b};
    sy_pc  <= {sy_pc[0], mode_strap_c};
  end

  // programmer mode caught after release, not under reset
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      strap_done_q    <= 1'b0;
      programmer_mode <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q    <= 1'b1;
      programmer_mode <= !sy_rst[1] && !sy_bw0[1] && sy_bw1[1]
                         && sy_pa[1] && !sy_pb[1] && !sy_pc[1];
    end
  end

  // halfword alignment and window check in programmer mode
  assign misalign = programmer_mode &&
                    (bus_addr[0] || bus_addr > `FCS_PROG_TOP);

  // command sequencer
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q                 <= S_IDLE;
      cnt_q                <= 32'h00000000;
      tmo_q                <= 32'h00000000;
      poll_q               <= 1'b0;
      ready_busy_flag      <= 1'b1;
      read_mode            <= 1'b1;
      status_byte          <= 8'h00;
      protect_query_result <= 32'h00000000;
      query_valid          <= 1'b0;
      access_error         <= 1'b0;
      op_start             <= 1'b0;
      op_kind              <= K_PROG;
      program_target_addr  <= 24'h000000;
      program_value        <= 32'h00000000;
      op_block             <= 5'h00;
      security_bit         <= 1'b0;
    end else begin
      op_start     <= 1'b0;
      query_valid  <= 1'b0;
      access_error <= (wr_stb || rd_stb) && misalign;
      case (st_q)
        // read mode: only the first unlock write moves on
        S_IDLE: begin
          read_mode <= 1'b1;
          if (wr_stb && !misalign && at_u1 && d8 == `FCS_DAT_UNLOCK1)
            st_q <= S_U1;
        end

        // first unlock seen; F0 at xxx0 cancels
        S_U1: begin
          if (is_reset1)
            st_q <= S_IDLE;
          else if (wr_stb)
            st_q <= (at_u2 && d8 == `FCS_DAT_UNLOCK2) ? S_U2 : S_IDLE;
        end

        // both unlocks seen; third write picks the command
        S_U2: begin
          if (wr_stb) begin
            st_q <= S_IDLE;
            if (at_u1) begin
              case (d8)
                `FCS_CMD_PROGRAM: st_q <= S_PGM;
                `FCS_CMD_ERASE:   st_q <= S_ERS;
                `FCS_CMD_VERIFY:  st_q <= S_VFY;
                default:          st_q <= S_IDLE; // F0, 9A and others: back to read
              endcase
            end
          end
        end

        // fourth write: program data or the security-on key
        S_PGM: begin
          if (is_reset1)
            st_q <= S_IDLE;
          else if (wr_stb && security_access_select) begin
            if (a16 == `FCS_ADDR_ZERO && d8 == `FCS_DAT_SECURE) begin
              op_kind <= K_SON;
              st_q    <= S_RUN;
            end else
              st_q <= S_IDLE;
          end else if (wr_stb) begin
            program_target_addr <= bus_addr;
            program_value       <= bus_wdata;
            op_kind             <= K_PROG;
            op_block            <= blk;
            st_q                <= S_RUN;
          end
          if (wr_stb && !is_reset1 && (security_access_select ?
              (a16 == `FCS_ADDR_ZERO && d8 == `FCS_DAT_SECURE) : 1'b1)) begin
            ready_busy_flag <= 1'b0;
            read_mode       <= 1'b0;
            op_start        <= 1'b1;
            cnt_q           <= 32'h00000000;
            tmo_q           <= 32'h00000000;
            poll_q          <= ~bus_wdata[7]; // complement until done
          end
        end

        // erase setup: second unlock pair must follow
        S_ERS: begin
          if (wr_stb)
            st_q <= (at_u1 && d8 == `FCS_DAT_UNLOCK1) ? S_EU1 : S_IDLE;
        end

        // erase setup, first unlock again
        S_EU1: begin
          if (wr_stb)
            st_q <= (at_u2 && d8 == `FCS_DAT_UNLOCK2) ? S_EU2 : S_IDLE;
        end

        // sixth write: chip erase or a block address
        S_EU2: begin
          if (wr_stb) begin
            st_q <= S_IDLE;
            if (at_u1 && d8 == `FCS_CMD_CHIP) begin
              op_kind         <= security_access_select ? K_SOFF : K_CHIP;
              st_q            <= S_RUN;
              ready_busy_flag <= 1'b0;
              read_mode       <= 1'b0;
              op_start        <= 1'b1;
              cnt_q           <= 32'h00000000;
              tmo_q           <= 32'h00000000;
              poll_q          <= 1'b0;
            end else if (d8 == `FCS_CMD_BLOCK && bus_addr[1:0] == 2'b00 &&
                         !security_access_select && !security_bit) begin
              op_kind   <= K_BLOCK;
              op_block  <= blk;
              st_q      <= S_WIN;
              read_mode <= 1'b0;
              cnt_q     <= 32'h00000000;
              tmo_q     <= 32'h00000000;
              poll_q    <= 1'b0;
            end
          end
        end

        // block erase waits out its window before starting
        S_WIN: begin
          // erase window: block erase restarts the window on a repeat
          status_byte <= 8'h00;
          if (wr_stb && d8 == `FCS_CMD_BLOCK && bus_addr[1:0] == 2'b00) begin
            op_block <= blk;
            cnt_q    <= 32'h00000000;
          end else if (cnt_q >= ERASE_WIN_CYC - 1) begin
            ready_busy_flag <= 1'b0;
            op_start        <= 1'b1;
            cnt_q           <= 32'h00000000;
            st_q            <= S_RUN;
          end else
            cnt_q <= cnt_q + 32'h00000001;
        end

        // verify: the next tagged read returns protection
        S_VFY: begin
          if (is_reset1)
            st_q <= S_IDLE;
          else if (rd_stb && !bus_addr[6] && bus_addr[4] && !bus_addr[3]
                   && bus_addr[1:0] == 2'b00) begin
            protect_query_result <= {31'h00000000, block_protect_map[blk]};
            query_valid          <= 1'b1;
            st_q                 <= S_IDLE;
          end else if (wr_stb)
            st_q <= S_IDLE;
        end

        // embedded operation running
        S_RUN: begin
          // commands ignored while busy; only the two timers and the status byte move
          cnt_q <= cnt_q + 32'h00000001;
          tmo_q <= tmo_q + 32'h00000001;
          status_byte <= {(op_kind == K_PROG) ? poll_q : 1'b0, 1'b0, 1'b0, 1'b0,
                          (op_kind == K_PROG) ? 1'b0 : 1'b1, 3'b000};
          if (op_fail || tmo_q >= TIMEOUT_CYC - 1) begin
            st_q <= S_FAIL;
          end else if (cnt_q >= OP_CYC - 1) begin
            ready_busy_flag <= 1'b1;
            st_q            <= S_IDLE;
            status_byte     <= 8'h00;
            if (op_kind == K_SON)
              security_bit <= 1'b1;
            else if (op_kind == K_SOFF)
              security_bit <= 1'b0;
          end
        end

        // failed or timed out
        S_FAIL: begin
          // stays locked with busy low until an F0 reset write at xxx0; reads do not release it
          status_byte <= {(op_kind == K_PROG) ? poll_q : 1'b0, 1'b0, 1'b1, 1'b0,
                          1'b1, 3'b000};
          if (is_reset1) begin
            st_q            <= S_IDLE;
            ready_busy_flag <= 1'b1;
            status_byte     <= 8'h00;
          end
        end

        // unused codes fall back to read mode
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule
